// ### hdl/fb_pin_pkg.sv
package fb_pin_pkg;

   // -------------------------------------------------------------
   // Sequencer states and request kinds
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ROW  = 3'b001,
      S_COL  = 3'b010,
      S_DAC  = 3'b011,
      S_ROM  = 3'b100,
      S_CLK  = 3'b101,
      S_END  = 3'b110
   } fsm_t;

   typedef enum logic [2:0] {
      OP_FB_RD  = 3'b000,
      OP_FB_WR  = 3'b001,
      OP_DAC_RD = 3'b010,
      OP_DAC_WR = 3'b011,
      OP_ROM_RD = 3'b100,
      OP_ROM_WR = 3'b101,
      OP_CLK    = 3'b110
   } op_t;

   // -------------------------------------------------------------
   // Column access-mode codes; all ones means no access
   // -------------------------------------------------------------
   localparam logic [1:0] CM_DIAG = 2'b00;
   localparam logic [1:0] CM_HORZ = 2'b01;
   localparam logic [1:0] CM_BCAST = 2'b10;
   localparam logic [1:0] CM_IDLE = 2'b11;

   // -------------------------------------------------------------
   // Phase lengths in fbclk cycles
   // -------------------------------------------------------------
   localparam logic [2:0] ROW_CYC = 3'h2;
   localparam logic [2:0] COL_CYC = 3'h2;
   localparam logic [2:0] DAC_CYC = 3'h3;
   localparam logic [2:0] ROM_CYC = 3'h4;
   localparam logic [2:0] CLK_CYC = 3'h2;

   // -------------------------------------------------------------
   // Reset levels of the pins
   // -------------------------------------------------------------
   localparam logic [1:0] ADDREN_RST = 2'h0;
   localparam logic [3:0] RAS_RST = 4'hf;
   localparam logic [3:0] RASEN_RST = 4'h0;
   localparam logic [3:0] CAS_RST = 4'hf;
   localparam logic [1:0] CASEN_RST = 2'h3;
   localparam logic [1:0] DSF_RST = 2'h0;
   localparam logic [1:0] OE_RST = 2'h3;
   localparam logic [7:0] WE_RST = 8'hff;
   localparam logic [1:0] DACCE_RST = 2'h3;

   // -------------------------------------------------------------
   // Request and pin groups
   // -------------------------------------------------------------
   typedef struct packed {
      op_t         op;
      logic [17:0] addr;
      logic [1:0]  bank;
      logic [1:0]  mode;
      logic        wide;
      logic [7:0]  weMask;
      logic [63:0] wdata;
   } req_t;

   typedef struct packed {
      logic [17:0] addr;
      logic [1:0]  addrenN;
      logic [3:0]  rasN;
      logic [3:0]  rasenN;
      logic [3:0]  casN;
      logic [1:0]  casen;
      logic [1:0]  casmode;
      logic [1:0]  dsf;
      logic [1:0]  oeN;
      logic [7:0]  weN;
      logic [2:0]  dacc;
      logic        dacrw;
      logic [1:0]  dacceN;
      logic        icsceN;
      logic        romceN;
      logic        romoeN;
      logic        romweN;
      logic [63:0] dataOut;
      logic        dataOeN;
   } pins_t;

   typedef struct packed {
      fsm_t        st;
      logic [2:0]  cnt;
      req_t        req;
      pins_t       pins;
      logic        rspValid;
      logic [63:0] rspData;
   } state_t;

endpackage

// ### hdl/fb_pin_if.sv
// Overview of operation
// - Address bus feeds glue and EEPROM directly
// - Address-logic enables held low in reset
// - Row sources high, row enables low in reset
// - Column sources, selects, mode high in reset
// - DAC pin roles set by mode input
// - Low DAC lines carry synthesizer data, hold
// - DAC selects high in reset
// - 64-bit shared bidirectional data bus
// - Special-function selects low in reset
// - All logic runs on the frame buffer clock
// - Synthesizer strobe high in reset
// - Output and write enables high in reset
// - EEPROM enables all high in reset
// - Access-mode lines encode diagonal, horizontal, broadcast
// - 8 bpp one bank, 32 bpp whole segment
`timescale 1ns/10ps
`default_nettype none

module fb_pin_if (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Configuration
   input wire logic dacRegSelMode,
   // Request side
   input wire logic reqValid,
   output logic reqReady,
   input wire fb_pin_pkg::req_t req,
   // Answer side
   output logic rspValid,
   output logic [63:0] rspData,
   // Pins
   output fb_pin_pkg::pins_t pins,
   input wire logic [63:0] dataIn
);
   import fb_pin_pkg::*;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [3:0] rasEnable(input logic [1:0] bank, input logic wide);
      logic [3:0] v;
      v = 4'h0;
      if (!wide) begin
         v = ~(4'h1 << bank);
      end
      return v;
   endfunction

   function automatic pins_t idlePins(input pins_t p);
      pins_t v;
      v = p;
      v.addrenN = 2'h3;
      v.rasN = RAS_RST;
      v.rasenN = 4'hf;
      v.casN = CAS_RST;
      v.casen = CASEN_RST;
      v.casmode = CM_IDLE;
      v.dsf = DSF_RST;
      v.oeN = OE_RST;
      v.weN = WE_RST;
      v.dacceN = DACCE_RST;
      v.icsceN = 1'b1;
      v.romceN = 1'b1;
      v.romoeN = 1'b1;
      v.romweN = 1'b1;
      v.dataOeN = 1'b1;
      return v;
   endfunction

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   state_t s_q;
   state_t s_d;
   logic take;

   assign reqReady = (s_q.st == S_IDLE);
   assign take = reqValid && reqReady;
   assign rspValid = s_q.rspValid;
   assign rspData = s_q.rspData;
   assign pins = s_q.pins;

   always_comb begin
      s_d = s_q;
      s_d.rspValid = 1'b0;
      case (s_q.st)
         S_IDLE: begin
            s_d.pins = idlePins(s_q.pins);
            if (take) begin
               s_d.req = req;
               s_d.pins.addr = req.addr;
               case (req.op)
                  OP_FB_RD, OP_FB_WR: begin
                     s_d.st = S_ROW;
                     s_d.cnt = ROW_CYC;
                     s_d.pins.addrenN = 2'h2;
                     s_d.pins.rasN = 4'h0;
                     s_d.pins.rasenN = rasEnable(req.bank, req.wide);
                     s_d.pins.dsf = {1'b0, req.mode == CM_BCAST};
                  end
                  OP_DAC_RD, OP_DAC_WR: begin
                     s_d.st = S_DAC;
                     s_d.cnt = DAC_CYC;
                     // Register-select part: four selects, separate strobes
                     if (dacRegSelMode) begin
                        {s_d.pins.dacc, s_d.pins.dacrw} = req.addr[3:0];
                        s_d.pins.dacceN = {req.op != OP_DAC_RD, req.op != OP_DAC_WR};
                     end else begin
                        s_d.pins.dacc = {1'b0, req.addr[1:0]};
                        s_d.pins.dacrw = (req.op == OP_DAC_RD);
                        s_d.pins.dacceN = req.addr[2] ? 2'h1 : 2'h2;
                     end
                     s_d.pins.dataOut = req.wdata;
                     s_d.pins.dataOeN = (req.op != OP_DAC_WR);
                  end
                  OP_ROM_RD, OP_ROM_WR: begin
                     s_d.st = S_ROM;
                     s_d.cnt = ROM_CYC;
                     s_d.pins.romceN = 1'b0;
                     s_d.pins.romoeN = (req.op != OP_ROM_RD);
                     s_d.pins.romweN = (req.op != OP_ROM_WR);
                     s_d.pins.dataOut = req.wdata;
                     s_d.pins.dataOeN = (req.op != OP_ROM_WR);
                  end
                  default: begin
                     // Serial bit in addr[0], hold level in addr[1]
                     s_d.st = S_CLK;
                     s_d.cnt = CLK_CYC;
                     s_d.pins.dacc[1:0] = {req.addr[1], req.addr[0]};
                     s_d.pins.icsceN = 1'b0;
                  end
               endcase
            end
         end
         S_ROW: begin
            s_d.cnt = s_q.cnt - 3'h1;
            if (s_q.cnt == 3'h1) begin
               s_d.st = S_COL;
               s_d.cnt = COL_CYC;
               s_d.pins.addrenN = 2'h1;
               s_d.pins.casN = 4'h0;
               s_d.pins.casen = s_q.req.bank;
               s_d.pins.casmode = s_q.req.mode;
               if (s_q.req.op == OP_FB_WR) begin
                  s_d.pins.weN = ~s_q.req.weMask;
                  s_d.pins.dataOut = s_q.req.wdata;
                  s_d.pins.dataOeN = 1'b0;
               end else begin
                  s_d.pins.oeN = 2'h0;
               end
            end
         end
         S_COL, S_DAC, S_ROM, S_CLK: begin
            s_d.cnt = s_q.cnt - 3'h1;
            if (s_q.cnt == 3'h1) begin
               // Read data is caught while the strobe is still held
               s_d.st = S_END;
               s_d.rspData = dataIn;
               s_d.pins = idlePins(s_q.pins);
            end
         end
         S_END: begin
            s_d.st = S_IDLE;
            s_d.rspValid = 1'b1;
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Registers; one clock for every pin
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q.st <= S_IDLE;
         s_q.cnt <= 3'h0;
         s_q.req <= '0;
         s_q.rspValid <= 1'b0;
         s_q.rspData <= 64'h0;
         // Undefined-at-reset pins are simply driven to zero
         s_q.pins.addr <= 18'h0;
         s_q.pins.addrenN <= ADDREN_RST;
         s_q.pins.rasN <= RAS_RST;
         s_q.pins.rasenN <= RASEN_RST;
         s_q.pins.casN <= CAS_RST;
         s_q.pins.casen <= CASEN_RST;
         s_q.pins.casmode <= CM_IDLE;
         s_q.pins.dsf <= DSF_RST;
         s_q.pins.oeN <= OE_RST;
         s_q.pins.weN <= WE_RST;
         s_q.pins.dacc <= 3'h0;
         s_q.pins.dacrw <= 1'b0;
         s_q.pins.dacceN <= DACCE_RST;
         s_q.pins.icsceN <= 1'b1;
         s_q.pins.romceN <= 1'b1;
         s_q.pins.romoeN <= 1'b1;
         s_q.pins.romweN <= 1'b1;
         s_q.pins.dataOut <= 64'h0;
         s_q.pins.dataOeN <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_addren_reset: assert property ($past(rst) |-> pins.addrenN == 2'h0)
      else $error("address enables not low after reset");
   a_row_reset: assert property ($past(rst) |-> pins.rasN == 4'hf && pins.rasenN == 4'h0)
      else $error("row pins wrong after reset");
   a_col_reset: assert property ($past(rst) |->
         pins.casN == 4'hf && pins.casen == 2'h3 && pins.casmode == 2'h3)
      else $error("column pins not high after reset");
   a_dacsel_reset: assert property ($past(rst) |-> pins.dacceN == 2'h3)
      else $error("dac selects not high after reset");
   a_sf_reset: assert property ($past(rst) |-> pins.dsf == 2'h0)
      else $error("special function not low after reset");
   a_synth_reset: assert property ($past(rst) |-> pins.icsceN)
      else $error("synth strobe not high after reset");
   a_ctl_reset: assert property ($past(rst) |-> pins.oeN == 2'h3 && pins.weN == 8'hff)
      else $error("output or write enable not high after reset");
   a_rom_reset: assert property ($past(rst) |->
         pins.romceN && pins.romoeN && pins.romweN)
      else $error("eeprom enables not high after reset");
   a_bank_open: assert property (take && (req.op == OP_FB_WR || req.op == OP_FB_RD) |=>
         pins.rasenN == ($past(req.wide) ? 4'h0 : ~(4'h1 << $past(req.bank))))
      else $error("row enable pattern wrong");
   a_mode_drive: assert property (take && req.op == OP_FB_WR |=> ##2
         pins.casmode == $past(req.mode, 3) && pins.weN == ~$past(req.weMask, 3))
      else $error("column mode or write mask wrong");
   a_fb_answer: assert property (take && req.op == OP_FB_RD |-> ##6 rspValid)
      else $error("frame buffer read answer late");
   a_synth_bits: assert property (take && req.op == OP_CLK |=>
         !pins.icsceN [*2] ##1 pins.icsceN)
      else $error("synth strobe width wrong");
   // Address settles with the chip enable, then must not move
   a_rom_addr: assert property (!pins.romceN |=> pins.romceN || $stable(pins.addr))
      else $error("eeprom address moved during access");
   a_dac_modeb: assert property (take && dacRegSelMode && req.op == OP_DAC_RD |=>
         pins.dacceN == 2'h1 && pins.dataOeN)
      else $error("dac read strobe wrong");
   a_dac_modea: assert property (take && !dacRegSelMode && req.op == OP_DAC_WR |=>
         pins.dacc[2] == 1'b0 && !pins.dacrw && !pins.dataOeN)
      else $error("dac write pins wrong in head-select wiring");
   a_dac_heads: assert property (take && !dacRegSelMode &&
         (req.op == OP_DAC_RD || req.op == OP_DAC_WR) |=>
         pins.dacceN == ($past(req.addr[2]) ? 2'h1 : 2'h2))
      else $error("dac head select wrong");
   a_dac_answer: assert property (take &&
         (req.op == OP_DAC_RD || req.op == OP_DAC_WR) |-> ##5 rspValid)
      else $error("dac answer not on time");
   a_rom_answer: assert property (take &&
         (req.op == OP_ROM_RD || req.op == OP_ROM_WR) |-> ##6 rspValid)
      else $error("eeprom answer not on time");
   a_clk_answer: assert property (take && req.op == OP_CLK |-> ##4 rspValid)
      else $error("synth answer not on time");
   a_rom_strobe: assert property (take &&
         (req.op == OP_ROM_RD || req.op == OP_ROM_WR) |=>
         !pins.romceN [*4] ##1 pins.romceN)
      else $error("eeprom enable width wrong");
   a_rom_read: assert property (take && req.op == OP_ROM_RD |=>
         !pins.romoeN && pins.romweN && pins.dataOeN)
      else $error("eeprom read strobes wrong");
   a_read_oe: assert property (take && req.op == OP_FB_RD |=> ##2
         pins.oeN == 2'h0 && pins.weN == 8'hff && pins.dataOeN)
      else $error("frame buffer read enables wrong");
   a_fb_wdata: assert property (take && req.op == OP_FB_WR |=> ##2
         !pins.dataOeN && pins.dataOut == $past(req.wdata, 3))
      else $error("frame buffer write data wrong");
   a_dsf_bcast: assert property (take && req.op == OP_FB_RD && req.mode == CM_BCAST |=>
         pins.dsf == 2'h1)
      else $error("broadcast special function wrong");
   // Data bus is only driven while no memory output is enabled
   a_bus_turn: assert property (!pins.dataOeN |-> pins.oeN == 2'h3 && pins.romoeN)
      else $error("data bus driven against a memory output");
   a_cas_mode: assert property (pins.casN == CAS_RST |-> pins.casmode == CM_IDLE)
      else $error("column mode shown without column strobe");
   a_ras_held: assert property (pins.casN == 4'h0 |-> pins.rasN == 4'h0)
      else $error("column strobe without open row");
   a_end_idle: assert property (s_q.st == S_END |->
         pins.oeN == 2'h3 && pins.weN == 8'hff && pins.addrenN == 2'h3 && pins.dataOeN)
      else $error("pins not idle after access");
   a_rsp_pulse: assert property (rspValid |-> reqReady ##1 !rspValid)
      else $error("answer pulse wrong");

   // -------------------------------------------------------------
   // Cover points
   // -------------------------------------------------------------
   c_fb_write: cover property (take && req.op == OP_FB_WR && !req.wide);
   c_fb_bcast: cover property (take && req.op == OP_FB_RD && req.mode == CM_BCAST);
   c_dac_modeb: cover property (take && dacRegSelMode && req.op == OP_DAC_WR);
   c_synth_bit: cover property (take && req.op == OP_CLK);
   c_rom_read: cover property (take && req.op == OP_ROM_RD);

endmodule

`default_nettype wire

// ### tb/fb_glue_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Glue logic and memory stand-in
// ----
module fb_glue_model
   import fb_pin_pkg::*;
#(
   parameter logic [63:0] AKEY = 64'h0,
   parameter logic [63:0] DKEY = 64'h0
) (
   // Clock
   input wire logic ref_clk,
   // Device pins and data bus
   input wire fb_pin_pkg::pins_t pins,
   output logic [63:0] dataIn
);
   logic [63:0] idle_q = 64'h5a5a_0ff0_a5a5_f00f;
   logic rdOn;
   // Answers only while the device has let go of the bus
   assign rdOn = pins.dataOeN && (pins.oeN != 2'h3 || !pins.romoeN || pins.dacceN != 2'h3);
   assign dataIn = !rdOn ? idle_q : (pins.dacceN != 2'h3 ? DKEY : AKEY ^ {46'h0, pins.addr});
   // Released bus keeps moving so a stale value never passes
   always_ff @(posedge ref_clk) begin
      idle_q <= ~dataIn;
   end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import fb_pin_pkg::*;
   localparam logic [63:0] AKEY = 64'h3c96_e187_d24b_1e69;
   localparam logic [63:0] DKEY = 64'h00c3_5aa5_ff18_7e81;
   typedef struct packed {logic rd; logic [63:0] val;} note_t;
   logic ref_clk = 1'b0, rst = 1'b1, dacRegSelMode = 1'b0, reqValid = 1'b0;
   req_t req = '0;
   logic reqReady, rspValid;
   logic [63:0] rspData, dataIn;
   pins_t pins;
   int errors = 0, checks_done = 0;
   integer seed = 67;
   note_t notes[$];

   fb_pin_if DUT (.ref_clk(ref_clk), .rst(rst), .dacRegSelMode(dacRegSelMode),
      .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
      .rspData(rspData), .pins(pins), .dataIn(dataIn));
   fb_glue_model #(.AKEY(AKEY), .DKEY(DKEY)) glue (.ref_clk(ref_clk), .pins(pins),
      .dataIn(dataIn));

   // ----
   // Clock, watchdog, closing
   // ----
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #300000;
      errors++;
      end_sim();
   end
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      chk("notesLeft", 64'h0, 64'(notes.size()));
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----
   // Drivers
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic rst_chk();
      chk("addrenN", 2'h0, pins.addrenN);
      chk("rasN", 4'hf, pins.rasN);
      chk("rasenN", 4'h0, pins.rasenN);
      chk("casPins", 8'hff, {pins.casN, pins.casen, pins.casmode});
      chk("dacceN", 2'h3, pins.dacceN);
      chk("dsf", 2'h0, pins.dsf);
      chk("icsceN", 1'b1, pins.icsceN);
      chk("oeWe", 10'h3ff, {pins.oeN, pins.weN});
      chk("romPins", 3'h7, {pins.romceN, pins.romoeN, pins.romweN});
      chk("dataOeN", 1'b0, pins.dataOeN);
   endtask
   task automatic do_rst(input int n);
      @(posedge ref_clk);
      rst <= 1'b1;
      tick(n);
      rst_chk();
      @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   task automatic op(input req_t r, input logic md);
      @(posedge ref_clk);
      reqValid <= 1'b1;
      req <= r;
      dacRegSelMode <= md;
      do @(posedge ref_clk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      tick(1);
   endtask
   function automatic req_t rnd(input op_t o);
      rnd.op = o;
      rnd.addr = 18'($random(seed));
      rnd.bank = 2'($random(seed));
      rnd.mode = CM_DIAG;
      rnd.wide = 1'b0;
      rnd.weMask = 8'($random(seed));
      rnd.wdata = {$random(seed), $random(seed)};
   endfunction
   task automatic fb(input logic wr, input logic [1:0] md, input logic wd);
      req_t r;
      logic [3:0] ren;
      r = rnd(wr ? OP_FB_WR : OP_FB_RD);
      r.mode = md;
      r.wide = wd;
      ren = wd ? 4'h0 : ~(4'h1 << r.bank);
      notes.push_back('{!wr, AKEY ^ {46'h0, r.addr}});
      op(r, 1'b0);
      chk("rowPins", {r.addr, 2'h2, 4'h0, ren}, {pins.addr, pins.addrenN, pins.rasN, pins.rasenN});
      chk("dsfRow", {1'b0, md == CM_BCAST}, pins.dsf);
      tick(2);
      chk("colPins", {2'h1, 4'h0, r.bank, md}, {pins.addrenN, pins.casN, pins.casen, pins.casmode});
      chk("oeWeCol", wr ? {2'h3, ~r.weMask} : 10'h0ff, {pins.oeN, pins.weN});
      if (wr) chk("fbData", {r.wdata, 1'b0}, {pins.dataOut, pins.dataOeN});
      tick(2);
      chk("fbDone", 2'h3, {rspValid, reqReady});
   endtask
   task automatic side(input op_t o, input logic md, input logic wr);
      req_t r;
      r = rnd(o);
      notes.push_back('{!wr && o != OP_CLK, o == OP_ROM_RD ? AKEY ^ {46'h0, r.addr} : DKEY});
      op(r, md);
      if (o == OP_CLK) begin
         chk("clkPins", {r.addr[1:0], 1'b0}, {pins.dacc[1:0], pins.icsceN});
         tick(2);
         chk("clkEnd", 1'b1, pins.icsceN);
      end else if (o == OP_DAC_RD || o == OP_DAC_WR) begin
         chk("dacPins", md ? {r.addr[3:0], wr ? 2'h2 : 2'h1} : {1'b0, r.addr[1:0], !wr,
            r.addr[2] ? 2'h1 : 2'h2}, {pins.dacc, pins.dacrw, pins.dacceN});
         tick(3);
      end else begin
         chk("romPins", {r.addr, 1'b0, wr, !wr}, {pins.addr, pins.romceN, pins.romoeN, pins.romweN});
         tick(4);
      end
      if (wr) chk("sideDone", 1'b1, rspValid);
   endtask

   // ----
   // Answer watcher
   // ----
   always @(posedge ref_clk) begin
      note_t n;
      #1;
      if (rspValid === 1'b1) begin
         if (notes.size() == 0) chk("spareRsp", 1'b0, 1'b1);
         else begin
            n = notes.pop_front();
            if (n.rd) chk("rspData", n.val, rspData);
         end
      end
   end

   // ----
   // Main sequence
   // ----
   initial begin
      do_rst(10);
      // Reads and writes through diagonal, horizontal and broadcast modes, narrow then wide
      for (int i = 0; i < 12; i++) fb(i[0], 2'(i % 3), i >= 6);
      for (int i = 0; i < 4; i++) side(i[0] ? OP_DAC_WR : OP_DAC_RD, i[1], i[0]);
      side(OP_ROM_RD, 1'b0, 1'b0);
      side(OP_ROM_WR, 1'b0, 1'b1);
      side(OP_CLK, 1'b0, 1'b1);
      // Reset lands in the column phase of a read
      op(rnd(OP_FB_RD), 1'b0);
      do_rst(2);
      fb(1'b1, CM_BCAST, 1'b1);
      fb(1'b0, CM_HORZ, 1'b0);
      tick(3);
      end_sim();
   end
endmodule
`default_nettype wire
